// ---- design/pie_pkg.sv ----
/*
  constants for the peripheral interrupt enable bank: register offsets,
  bit positions, reset values and status layout.
  assumes a plain 8-bit register port on the core side.
*/
package pie_pkg;

  // register offsets on the plain register port
  localparam logic [3:0] OFS_ENABLE_1 = 4'h0; // periph_irq_enable_1
  localparam logic [3:0] OFS_ENABLE_2 = 4'h1; // periph_irq_enable_2
  localparam logic [3:0] OFS_ENABLE_3 = 4'h2; // periph_irq_enable_3
  localparam logic [3:0] OFS_CONTROL = 4'h3; // mode and global enables
  localparam logic [3:0] OFS_PRIORITY_1 = 4'h4; // periph_irq_priority_1
  localparam logic [3:0] OFS_EVT_STATUS = 4'h5; // sticky event status, RO
  localparam logic [3:0] OFS_EVT_CLEAR = 4'h6; // write one to clear, WO
  localparam logic [3:0] OFS_EVT_ENABLE = 4'h7; // event interrupt enable

  // writable masks of the three enable registers, the control register and the event enable register
  localparam logic [7:0] MASK_ENABLE_1 = 8'hFF;
  localparam logic [7:0] MASK_ENABLE_2 = 8'hC9; // bits 7,6,3,0
  localparam logic [7:0] MASK_ENABLE_3 = 8'hC0; // bits 7,6
  localparam logic [7:0] MASK_CONTROL = 8'h07;
  localparam logic [7:0] MASK_EVENTS = 8'h07;

  // bit positions, first enable register
  localparam int BIT_PARALLEL_SLAVE = 7;
  localparam int BIT_ADC = 6;
  localparam int BIT_SERIAL_RX = 5;
  localparam int BIT_SERIAL_TX = 4;
  localparam int BIT_SYNC_PORT1 = 3;
  localparam int BIT_CAPCOMP1 = 2;
  localparam int BIT_TIMER2_MATCH = 1;
  localparam int BIT_TIMER1_OVERFLOW = 0;
  // second enable register
  localparam int BIT_OSC_FAIL = 7;
  localparam int BIT_COMPARATOR = 6;
  localparam int BIT_BUS_COLLISION1 = 3;
  localparam int BIT_CAPCOMP2 = 0;
  // third enable register
  localparam int BIT_SYNC_PORT2 = 7;
  localparam int BIT_BUS_COLLISION2 = 6;

  // control register fields
  localparam int BIT_PRIORITY_MODE = 0; // priority_mode_enable
  localparam int BIT_GLOBAL_PERIPH = 1; // global_periph_irq_enable
  localparam int BIT_GLOBAL_LOW = 2; // low-priority global enable

  // event status bits
  localparam int EVT_HIGH_REQ = 0; // high request rose
  localparam int EVT_LOW_REQ = 1; // low request rose
  localparam int EVT_MASKED_FLAG = 2; // flag set with enable 0 now but not last cycle

  // reset values
  localparam logic [7:0] RST_ENABLE = 8'h00;
  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam logic [7:0] RST_PRIORITY = 8'hFF;
  localparam logic [7:0] RST_EVENTS = 8'h00;

endpackage : pie_pkg

// ---- design/pie_bank.sv ----
/*
  peripheral interrupt enable bank: three enable registers gating the
  peripheral request flags, a control register with mode and global
  enables, a priority register and an event status interrupt.
  assumes flags come from peripherals already synchronous to clk and
  held until software clears them at the peripheral.
*/
// The address-and-strobe port and the address map were decided locally.
`timescale 1ns/1ns

// Contract
// RL1 - non-priority mode needs global peripheral enable
// RL2 - three separate peripheral enable registers
// RL3 - enable1 bit7 gates parallel slave port
// RL4 - small package: parallel slave bit reads zero
// RL5 - enable1 bit6 gates converter completion
// RL6 - enable1 bits5,4 gate serial receive, transmit
// RL7 - enable1 bit3 gates sync port 1
// RL8 - enable1 bit2 gates capture compare 1
// RL9 - enable1 bit1 gates timer2 period match
// RL10 - enable1 bit0 gates timer1 overflow
// RL11 - enable2 bits7,6 gate oscillator fail, comparator
// RL12 - enable2 bits3,0 collision1, capcomp2; others zero
// RL13 - enable3 bit7 gates sync port 2
// RL14 - enable3 bit6 gates bus collision 2
// RL15 - enable3 bits5..0 unimplemented, read zero
// RL16 - enable bits read-write, reset to zero
// RL17 - priorities matter only in priority mode
// RL18 - flags stay set until software clears
// RL19 - request needs flag and enable both set
module pie_bank #(
  parameter bit HAS_PARALLEL_SLAVE = 1'b1 // 0 on the smallest package
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // peripheral request flags, same layout as the enable registers
  input wire logic [7:0] periph_flag_1,
  input wire logic [7:0] periph_flag_2,
  input wire logic [7:0] periph_flag_3,
  // requests towards the core
  output logic core_irq_high,
  output logic core_irq_low,
  // event status interrupt
  output logic evt_irq
);

  // whole state of the bank
  typedef struct packed {
    logic [7:0] enable_1;
    logic [7:0] enable_2;
    logic [7:0] enable_3;
    logic [7:0] control;
    logic [7:0] priority_1;
    logic [7:0] evt_status;
    logic [7:0] evt_enable;
    logic [23:0] masked_prev; // last cycle's flags with enable off
    logic [7:0] rdata;
    logic irq_high;
    logic irq_low;
    logic evt_irq;
  } pie_state_t;

  pie_state_t st; // registered state
  pie_state_t next_st; // next state

  // writable mask of enable 1, parallel slave bit may be absent
  logic [7:0] mask_enable_1;

  // per-register decode, used on both write and read paths
  function automatic logic hit(input logic [3:0] a, input logic [3:0] o);
    hit = (a == o);
  endfunction : hit

  // absent parallel slave bit is never stored, so it reads zero
  always_comb begin
    mask_enable_1 = pie_pkg::MASK_ENABLE_1;
    if (!HAS_PARALLEL_SLAVE) begin
      mask_enable_1[pie_pkg::BIT_PARALLEL_SLAVE] = 1'b0; // RL4
    end
  end

  // next-state logic
  always_comb begin
    logic [23:0] flags; // all request flags
    logic [23:0] enables; // all enable bits
    logic [23:0] prio; // priority per source, 1 = high
    logic [23:0] pending; // flag and enable both set
    logic [23:0] masked_now; // flag set but enable off
    logic global_ok; // global gate, mode dependent
    logic any_high;
    logic any_low;
    logic [7:0] evt_set;
    flags = '0;
    enables = '0;
    prio = '0;
    pending = '0;
    masked_now = '0;
    global_ok = 1'b0;
    any_high = 1'b0;
    any_low = 1'b0;
    evt_set = '0;
    next_st = st;

    // register writes; reserved bits are masked off so they stay zero
    if (reg_wr) begin
      if (hit(reg_addr, pie_pkg::OFS_ENABLE_1)) begin
        next_st.enable_1 = reg_wdata & mask_enable_1; // RL3 RL16
      end
      if (hit(reg_addr, pie_pkg::OFS_ENABLE_2)) begin
        next_st.enable_2 = reg_wdata & pie_pkg::MASK_ENABLE_2; // RL12
      end
      if (hit(reg_addr, pie_pkg::OFS_ENABLE_3)) begin
        next_st.enable_3 = reg_wdata & pie_pkg::MASK_ENABLE_3; // RL15
      end
      if (hit(reg_addr, pie_pkg::OFS_CONTROL)) begin
        next_st.control = reg_wdata & pie_pkg::MASK_CONTROL;
      end
      if (hit(reg_addr, pie_pkg::OFS_PRIORITY_1)) begin
        next_st.priority_1 = reg_wdata;
      end
      if (hit(reg_addr, pie_pkg::OFS_EVT_ENABLE)) begin
        next_st.evt_enable = reg_wdata & pie_pkg::MASK_EVENTS;
      end
      if (hit(reg_addr, pie_pkg::OFS_EVT_CLEAR)) begin
        next_st.evt_status = st.evt_status & ~reg_wdata;
      end
    end

    // gather sources; flags are held by the peripherals themselves,
    // so gating is purely combinational on the held level
    flags = {periph_flag_3, periph_flag_2, periph_flag_1}; // RL18
    // each bit of the three registers gates its own flag position
    enables = {st.enable_3, st.enable_2, st.enable_1}; // RL2
    // only the first priority register is held here; the rest default
    // to high priority, matching the reset state of the priority bits
    prio = {16'hFFFF, st.priority_1};
    // one enable per flag: RL5 RL6 RL7 RL8 RL9 RL10 RL11 RL13 RL14
    pending = flags & enables; // RL19
    masked_now = flags & ~enables;

    // global gate and priority split
    if (st.control[pie_pkg::BIT_PRIORITY_MODE]) begin
      // priority mode: high goes straight, low needs the low gate
      any_high = |(pending & prio); // RL17
      any_low = |(pending & ~prio) && st.control[pie_pkg::BIT_GLOBAL_LOW];
    end else begin
      // no priority: every source is treated as high, global gate
      global_ok = st.control[pie_pkg::BIT_GLOBAL_PERIPH]; // RL1
      any_high = (|pending) && global_ok; // RL1 RL17
      any_low = 1'b0;
    end
    next_st.irq_high = any_high;
    next_st.irq_low = any_low;

    // events: rising requests and newly masked flags
    evt_set[pie_pkg::EVT_HIGH_REQ] = any_high && !st.irq_high;
    evt_set[pie_pkg::EVT_LOW_REQ] = any_low && !st.irq_low;
    evt_set[pie_pkg::EVT_MASKED_FLAG] = |(masked_now & ~st.masked_prev);
    next_st.masked_prev = masked_now;
    // set wins over a clear in the same cycle
    next_st.evt_status = next_st.evt_status | evt_set;
    next_st.evt_irq = |(next_st.evt_status & next_st.evt_enable);

    // read data stands the cycle after the strobe only
    next_st.rdata = 8'h00;
    if (reg_rd) begin
      if (hit(reg_addr, pie_pkg::OFS_ENABLE_1)) begin
        next_st.rdata = st.enable_1; // RL4
      end else if (hit(reg_addr, pie_pkg::OFS_ENABLE_2)) begin
        next_st.rdata = st.enable_2; // RL12
      end else if (hit(reg_addr, pie_pkg::OFS_ENABLE_3)) begin
        next_st.rdata = st.enable_3; // RL15
      end else if (hit(reg_addr, pie_pkg::OFS_CONTROL)) begin
        next_st.rdata = st.control;
      end else if (hit(reg_addr, pie_pkg::OFS_PRIORITY_1)) begin
        next_st.rdata = st.priority_1;
      end else if (hit(reg_addr, pie_pkg::OFS_EVT_STATUS)) begin
        next_st.rdata = st.evt_status;
      end else if (hit(reg_addr, pie_pkg::OFS_EVT_ENABLE)) begin
        next_st.rdata = st.evt_enable;
      end else begin
        // clear register and unmapped offsets read zero
        next_st.rdata = 8'h00;
      end
    end
  end

  // state register; all enables start cleared
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st.enable_1 <= pie_pkg::RST_ENABLE; // RL16
      st.enable_2 <= pie_pkg::RST_ENABLE; // RL16
      st.enable_3 <= pie_pkg::RST_ENABLE; // RL16
      st.control <= pie_pkg::RST_CONTROL;
      st.priority_1 <= pie_pkg::RST_PRIORITY;
      st.evt_status <= pie_pkg::RST_EVENTS;
      st.evt_enable <= pie_pkg::RST_EVENTS;
      st.masked_prev <= '0;
      st.rdata <= 8'h00;
      st.irq_high <= 1'b0;
      st.irq_low <= 1'b0;
      st.evt_irq <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from flip-flops
  assign reg_rdata = st.rdata;
  assign core_irq_high = st.irq_high;
  assign core_irq_low = st.irq_low;
  assign evt_irq = st.evt_irq;

endmodule : pie_bank

// ---- verif/pie_bank_properties.sv ----
/* port checker for the enable bank: readback, idle read data, reset
   and request gating; assumes a bind from the bench top */
`timescale 1ns/1ns
module pie_bank_properties (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // flags and requests
  input wire logic [7:0] periph_flag_1,
  input wire logic [7:0] periph_flag_2,
  input wire logic [7:0] periph_flag_3,
  input wire logic core_irq_high,
  input wire logic core_irq_low,
  input wire logic evt_irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // a write then read of one offset returns only the stored bits
  property p_back(logic [3:0] a, logic [7:0] m);
    reg_wr && reg_addr == a ##1 reg_rd && reg_addr == a
      |=> reg_rdata == ($past(reg_wdata, 2) & m);
  endproperty
  chk_back_one: assert property (p_back(4'h0, 8'hFF))
    else $error("enable 1 readback wrong");
  chk_back_two: assert property (p_back(4'h1, 8'hC9))
    else $error("enable 2 readback wrong");
  chk_back_three: assert property (p_back(4'h2, 8'hC0))
    else $error("enable 3 readback wrong");
  chk_rdata_idle: assert property (!$past(reg_rd) |->
    reg_rdata == 8'h00) else $error("read data not zero outside a read");
  chk_unmapped_zero: assert property (reg_rd && reg_addr[3] |=>
    reg_rdata == 8'h00) else $error("unmapped read not zero");
  chk_reset_quiet: assert property (!$past(nrst) |->
    !core_irq_high && !core_irq_low && !evt_irq)
    else $error("request right after reset");
  // with no implemented flag up there is nothing to pass on
  chk_no_flag_quiet: assert property ($past(periph_flag_1) == 8'h00 &&
    $past(periph_flag_2 & 8'hC9) == 8'h00 &&
    $past(periph_flag_3 & 8'hC0) == 8'h00 |-> !core_irq_high && !core_irq_low)
    else $error("request without a flag");
  // only sources of the first register carry a priority choice
  chk_low_from_one: assert property (core_irq_low |->
    $past(periph_flag_1) != 8'h00) else $error("low request without source");
  cover property (core_irq_high);
  cover property (core_irq_low);
  cover property (evt_irq);
endmodule : pie_bank_properties

// ---- verif/pie_periph_model.sv ----
/* peripheral flag model: a flag rises on an event pulse and holds
   until a clear; assumes pulses are one clk cycle wide */
`timescale 1ns/1ns
module pie_periph_model (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // events and clears, flag word 3 in the top byte
  input wire logic [23:0] evt,
  input wire logic [23:0] clr,
  // flags towards the bank
  output logic [7:0] flag_1,
  output logic [7:0] flag_2,
  output logic [7:0] flag_3
);
  logic [23:0] fl; // held flags
  // set wins over clear so no event is lost; absent sources stay low
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) fl <= 24'h000000;
    else fl <= ((fl & ~clr) | evt) & 24'hC0C9FF;
  end
  assign {flag_3, flag_2, flag_1} = fl;
endmodule : pie_periph_model

// ---- verif/pie_bank_tb_top.sv ----
/* bench for the enable bank: directed reset, readback and event
   cases, then random writes and flag traffic against a shadow */
`timescale 1ns/1ns
module pie_bank_tb_top;
  logic clk, nrst, reg_wr, reg_rd, core_irq_high, core_irq_low, evt_irq;
  logic [3:0] reg_addr, a;
  logic [7:0] reg_wdata, reg_rdata, d, e1, e2, e3, ctl, pri;
  logic [7:0] periph_flag_1, periph_flag_2, periph_flag_3;
  logic [23:0] evt, clr; // partner stimulus
  int seed, i, cyc, err_total, checks_done;
  pie_bank pie_bank_inst (.clk(clk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .periph_flag_1(periph_flag_1),
    .periph_flag_2(periph_flag_2), .periph_flag_3(periph_flag_3),
    .core_irq_high(core_irq_high), .core_irq_low(core_irq_low),
    .evt_irq(evt_irq));
  pie_periph_model pie_periph_model_inst (.clk(clk), .nrst(nrst),
    .evt(evt), .clr(clr), .flag_1(periph_flag_1),
    .flag_2(periph_flag_2), .flag_3(periph_flag_3));
  // expected {high, low}: no global gate for high in priority mode
  function automatic logic [7:0] want();
    logic [7:0] h;
    h = periph_flag_1 & e1 & (ctl[0] ? pri : 8'hFF);
    want = {6'h00, |(h | (periph_flag_2 & e2) | (periph_flag_3 & e3))
      & (ctl[0] | ctl[1]), ctl[0] & ctl[2] & |(periph_flag_1 & e1 & ~pri)};
  endfunction : want
  function automatic logic [7:0] shadow(input logic [3:0] x);
    shadow = x == 0 ? e1 : x == 1 ? e2 : x == 2 ? e3 : x == 3 ? ctl : pri;
  endfunction : shadow
  task automatic chk(input string n, input logic [7:0] x, input logic [7:0] g);
    checks_done++;
    if (g !== x) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", n, x, g);
    end
  endtask : chk
  // one bus cycle, launched at an edge, taken at the next
  task automatic op(input logic w, r, input logic [3:0] x,
    input logic [7:0] v);
    reg_wr <= w;
    reg_rd <= r;
    reg_addr <= x;
    reg_wdata <= v;
    @(posedge clk);
  endtask : op
  task automatic idle(input int n);
    repeat (n) op(1'b0, 1'b0, 4'h0, 8'h00);
  endtask : idle
  // read data stand in the cycle after the read only
  task automatic rd(input logic [3:0] x, input logic [7:0] v);
    op(1'b0, 1'b1, x, 8'h00);
    idle(1);
    chk("reg_rdata", v, reg_rdata);
  endtask : rd
  task automatic close_out;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : close_out
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // hang guard, well above the roughly 1460 cycles the run needs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      close_out();
    end
  end
  initial begin
    {nrst, reg_wr, reg_rd, reg_addr, reg_wdata, evt, clr} = '0;
    {cyc, err_total, checks_done, e1, e2, e3, ctl} = '0;
    seed = 99026;
    pri = 8'hFF;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    // reset values, unmapped offsets 8 and 9 among them; clear is write-only
    for (i = 0; i < 10; i++) begin
      if (i != 6) begin
        rd(4'(i), i == 4 ? 8'hFF : 8'h00);
      end
    end
    // all ones back to back with a read: reserved bits are refused
    op(1'b1, 1'b0, 4'h0, 8'hFF);
    rd(4'h0, 8'hFF);
    op(1'b1, 1'b0, 4'h1, 8'hFF);
    rd(4'h1, 8'hC9);
    op(1'b1, 1'b0, 4'h2, 8'hFF);
    rd(4'h2, 8'hC0);
    {e2, e3} = 16'hC9C0;
    // a flag behind a cleared enable: no request, event raised
    op(1'b1, 1'b0, 4'h0, 8'h00);
    op(1'b1, 1'b0, 4'h7, 8'h04);
    evt <= 24'h000001;
    idle(1);
    evt <= 24'h000000;
    idle(4);
    chk("irq", want(), {6'h00, core_irq_high, core_irq_low});
    chk("evt_irq", 8'h01, {7'h00, evt_irq});
    rd(4'h5, 8'h04);
    op(1'b1, 1'b0, 4'h7, 8'h00);
    idle(2);
    chk("evt_irq", 8'h00, {7'h00, evt_irq});
    op(1'b1, 1'b0, 4'h7, 8'h04);
    op(1'b1, 1'b0, 4'h6, 8'h04);
    idle(2);
    chk("evt_irq", 8'h00, {7'h00, evt_irq});
    // random mode, enables, priority and flag traffic
    for (i = 0; i < 200; i++) begin
      a = 4'({$random(seed)} % 5);
      d = 8'($random(seed));
      op(1'b1, 1'b0, a, d);
      case (a)
        4'h0: e1 = d;
        4'h1: e2 = d & 8'hC9;
        4'h2: e3 = d & 8'hC0;
        4'h3: ctl = d & 8'h07;
        default: pri = d;
      endcase
      rd(a, shadow(a));
      evt <= 24'($random(seed)) & 24'($random(seed));
      clr <= 24'($random(seed));
      idle(1);
      evt <= 24'h000000;
      clr <= 24'h000000;
      idle(3);
      chk("irq", want(), {6'h00, core_irq_high, core_irq_low});
    end
    close_out();
  end
endmodule : pie_bank_tb_top
bind pie_bank pie_bank_properties pie_bank_properties_inst (.clk(clk),
  .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .periph_flag_1(periph_flag_1), .periph_flag_2(periph_flag_2),
  .periph_flag_3(periph_flag_3), .core_irq_high(core_irq_high),
  .core_irq_low(core_irq_low), .evt_irq(evt_irq));
